// ---- rtl/sirq_pkg.sv ----
/*
  Shared constants and types for the sensor interrupt and result block.
  Assumes a 50 MHz system clock and a host on a serial register link.
*/
package sirq_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] ADDR_PRESS_0 = 7'h04;
  localparam logic [6:0] ADDR_TEMP_2 = 7'h09;
  localparam logic [6:0] ADDR_INT_STATUS = 7'h11;
  localparam logic [6:0] ADDR_QLEN_0 = 7'h12;
  localparam logic [6:0] ADDR_QLEN_1 = 7'h13;
  localparam logic [6:0] ADDR_WTM_LOW = 7'h15;
  localparam logic [6:0] ADDR_WTM_HIGH = 7'h16;
  localparam logic [6:0] ADDR_INT_CTRL = 7'h19;
  localparam logic [6:0] ADDR_PWR_CTRL = 7'h1b;
  localparam logic [6:0] ADDR_OSR = 7'h1c;
  localparam logic [6:0] ADDR_ODR = 7'h1d;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_INT_CTRL = 8'h02;
  localparam logic [7:0] RST_WTM_LOW = 8'h01;
  localparam logic [7:0] RST_WTM_HIGH = 8'h00;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  localparam logic [7:0] RST_OSR = 8'h02;
  localparam logic [7:0] RST_ODR = 8'h00;
  localparam logic [7:0] MASK_INT_CTRL = 8'h7f;
  localparam logic [7:0] MASK_WTM_HIGH = 8'h01;
  localparam logic [7:0] MASK_PWR_CTRL = 8'h33;
  localparam logic [7:0] MASK_OSR = 8'h3f;
  localparam logic [7:0] MASK_ODR = 8'h1f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IRQ_OPEN_DRAIN_SELECT_BIT = 0;
  localparam int INT_LEVEL_BIT = 1;
  localparam int INT_LATCH_BIT = 2;
  localparam int FWTM_EN_BIT = 3;
  localparam int FFULL_EN_BIT = 4;
  localparam int DRDY_EN_BIT = 6;
  localparam int STAT_FWM_BIT = 0;
  localparam int STAT_FFULL_BIT = 1;
  localparam int STAT_DRDY_BIT = 3;
  localparam int PWR_PRESS_BIT = 0;
  localparam int PWR_TEMP_BIT = 1;
  localparam int PWR_MODE_LSB = 4;
  localparam int OSR_T_LSB = 3;
  localparam logic [8:0] FULL_LEVEL = 9'd504;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int US_CYCLES = 1000 / CLOCK_PERIOD_NS;
  localparam int DRDY_HOLD_US = 2500;
  localparam int DRDY_HOLD_CYCLES = DRDY_HOLD_US * US_CYCLES;
  localparam logic [31:0] CONV_BASE_US = 32'd234;
  localparam logic [31:0] CONV_PRESS_US = 32'd392;
  localparam logic [31:0] CONV_TEMP_US = 32'd163;
  localparam logic [31:0] CONV_OSR_US = 32'd2020;
  localparam logic [31:0] ODR_BASE_US = 32'd5000;
  localparam logic [2:0] OSR_MAX = 3'd5;
  localparam logic [4:0] ODR_MAX = 5'd17;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_FORCED_A = 2'b01,
    MODE_FORCED_B = 2'b10,
    MODE_NORMAL = 2'b11
  } sirq_mode_type;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_WAIT = 2'b10
  } sirq_phase_type;
  typedef struct packed {
    logic [23:0] press;
    logic [23:0] temp;
  } sirq_result_type;
  typedef struct packed {
    logic s1, s2, s3, lvl, rise, fall;
  } sirq_sync_type;
  typedef struct packed {
    sirq_phase_type phase;
    logic [11:0] pre;
    logic [31:0] conv_us;
    logic [31:0] period_us;
    logic done;
  } sirq_conv_type;
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic first, is_read;
    logic [6:0] addr;
    logic [7:0] rx, tx;
    logic [7:0] int_ctrl, wtm_lo, wtm_hi, pwr, osr, odr;
    logic [8:0] wtm_eff;
    logic wtm_written;
    logic fwm, ffull, drdy;
    logic [2:0] clr_mask;
    logic drdy_pin, drdy_run;
    logic [19:0] drdy_timer;
    sirq_result_type vis, shadow;
    logic shadow_pending, result_reading;
    logic forced_start, done_out, irq_out, irq_oe;
  } sirq_top_type;
endpackage

// ---- rtl/sirq_pin_sync.sv ----
/*
  Three-stage synchroniser with agreement filter and edge pulses.
  Assumes an input from outside the CLOCK domain.
*/
`timescale 1ns/1ps
module sirq_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  sirq_pkg::sirq_sync_type st, next_st;

  // ----------------------------------------
  // Filter: a change counts once stages two and three agree
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.s2 == st.s3 && st.s3 != st.lvl) begin
      next_st.lvl = st.s3;
      next_st.rise = st.s3;
      next_st.fall = ~st.s3;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '{IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
  assign rise = st.rise;
  assign fall = st.fall;
endmodule

// ---- rtl/sirq_conv_timer.sv ----
/*
  Conversion sequencer: forced single shots and the normal-mode cadence.
  Assumes settings are stable while a conversion runs.
*/
`timescale 1ns/1ps
module sirq_conv_timer #(
  parameter int US_CYCLES = sirq_pkg::US_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic forced_start,
  input wire logic [1:0] mode,
  input wire logic press_en,
  input wire logic temp_en,
  input wire logic [2:0] osr_p,
  input wire logic [2:0] osr_t,
  input wire logic [4:0] odr_sel,
  output logic done
);
  sirq_pkg::sirq_conv_type st, next_st;
  logic tick;
  logic normal;

  function automatic logic [31:0] osr_time(input logic [2:0] osr);
    logic [2:0] o;
    o = (osr > sirq_pkg::OSR_MAX) ? sirq_pkg::OSR_MAX : osr;
    return sirq_pkg::CONV_OSR_US << o;
  endfunction

  function automatic logic [31:0] conv_time();
    logic [31:0] t;
    t = sirq_pkg::CONV_BASE_US;
    if (press_en) begin
      t = t + sirq_pkg::CONV_PRESS_US + osr_time(osr_p);
    end
    if (temp_en) begin
      t = t + sirq_pkg::CONV_TEMP_US + osr_time(osr_t);
    end
    return t;
  endfunction

  function automatic logic [31:0] period_time();
    logic [4:0] s;
    s = (odr_sel > sirq_pkg::ODR_MAX) ? sirq_pkg::ODR_MAX : odr_sel;
    return sirq_pkg::ODR_BASE_US << s;
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // A slow conversion stretches the period: the next start waits for it.
  always_comb begin
    tick = (st.pre == 12'(US_CYCLES - 1));
    normal = (mode == sirq_pkg::MODE_NORMAL);
    next_st = st;
    next_st.done = 1'b0;
    next_st.pre = tick ? 12'h000 : st.pre + 12'h001;
    case (st.phase)
      sirq_pkg::CONV_IDLE: begin
        if (forced_start || normal) begin
          next_st.phase = sirq_pkg::CONV_RUN;
          next_st.conv_us = conv_time();
          next_st.period_us = period_time();
          next_st.pre = 12'h000;
        end
      end
      sirq_pkg::CONV_RUN: begin
        if (tick) begin
          if (st.period_us != 32'h0) begin
            next_st.period_us = st.period_us - 32'h1;
          end
          if (st.conv_us <= 32'h1) begin
            next_st.done = 1'b1;
            next_st.phase = normal ? sirq_pkg::CONV_WAIT
                                   : sirq_pkg::CONV_IDLE;
          end else begin
            next_st.conv_us = st.conv_us - 32'h1;
          end
        end
      end
      sirq_pkg::CONV_WAIT: begin
        if (!normal) begin
          next_st.phase = sirq_pkg::CONV_IDLE;
        end else if (tick) begin
          if (st.period_us <= 32'h1) begin
            next_st.phase = sirq_pkg::CONV_RUN;
            next_st.conv_us = conv_time();
            next_st.period_us = period_time();
          end else begin
            next_st.period_us = st.period_us - 32'h1;
          end
        end
      end
      default: begin
        next_st.phase = sirq_pkg::CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '{sirq_pkg::CONV_IDLE, 12'h000, 32'h0, 32'h0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule

// ---- rtl/sirq_top.sv ----
/*
  Interrupt generation and result shadowing for a pressure sensor,
  with its serial register slave. Assumes the queue storage lives
  outside and reports its unread byte count; measurement values arrive
  on MEASUREMENT_SAMPLE and are sampled on the clock edge that raises MEASURE_DONE.
*/
// Overview of operation
// - Watermark condition holds once queued bytes reach the programmed limit.
// - A zero watermark never raises the watermark condition.
// - Watermark is re-evaluated when a burst that wrote it ends.
// - Full status sets when unread bytes reach 504 or more.
// - Reading full status as one clears it if count is below 504.
// - Full source reaches the pin only with its enable set.
// - Latch bit picks latched status or live condition for the pin.
// - Data-ready sets at measurement end; reading it as one clears it.
// - Data-ready reaches the pin only with its enable set.
// - Non-latched data-ready pin contribution drops 2.5 ms after rising.
// - Latched-to-non-latched switch starts no timer until next data-ready.
// - Enabling data-ready late keeps pin low until the next event.
// - Conversion time follows base plus per-sensor oversampling terms.
// - Continuous mode rate is 200 Hz over two to the rate field.
// - Results are unsigned 24-bit, readable in one burst.
// - Results finishing during a result burst go to shadow registers.
// - Chip-select rising copies shadowed results to visible ones at once.
// - Enabled pin contributions are ORed onto the one pin.
// - After reset the pin is push-pull and active high.
// - Non-latched queue contributions follow only their conditions.
// - Status bits follow events whatever the pin settings.
`timescale 1ns/1ps
module sirq_top #(
  parameter int US_CYCLES = sirq_pkg::US_CYCLES,
  parameter int DRDY_HOLD_CYCLES = sirq_pkg::DRDY_HOLD_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  input wire logic [8:0] QUEUE_BYTES,
  input wire sirq_pkg::sirq_result_type MEASUREMENT_SAMPLE,
  output logic MEASURE_DONE,
  output logic IRQ_OUT,
  output logic IRQ_OE
);
  sirq_pkg::sirq_top_type st, next_st;
  logic [2:0] pins;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic conv_done;
  logic cs_sel;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic full_cond;
  logic wtm_cond;
  logic latch;
  logic active;
  logic c_fwm;
  logic c_full;
  logic [2:0] clr;
  logic [7:0] byte_in;
  logic [6:0] rd_addr;
  logic do_load;

  // ----------------------------------------
  // Link inputs
  // ----------------------------------------
  assign pins = {SERIAL_DATA_IN, SERIAL_CLOCK, CHIP_SELECT_N};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      sirq_pin_sync #(
        .IDLE_LEVEL(1'(gi == 0))
      ) u_sync (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .pin_in(pins[gi]),
        .level(lvl[gi]),
        .rise(rise[gi]),
        .fall(fall[gi])
      );
    end
  endgenerate

  sirq_conv_timer #(
    .US_CYCLES(US_CYCLES)
  ) u_conv (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .forced_start(st.forced_start),
    .mode(st.pwr[sirq_pkg::PWR_MODE_LSB +: 2]),
    .press_en(st.pwr[sirq_pkg::PWR_PRESS_BIT]),
    .temp_en(st.pwr[sirq_pkg::PWR_TEMP_BIT]),
    .osr_p(st.osr[2:0]),
    .osr_t(st.osr[sirq_pkg::OSR_T_LSB +: 3]),
    .odr_sel(st.odr[4:0]),
    .done(conv_done)
  );

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input logic [6:0] a,
      input sirq_pkg::sirq_top_type s, input logic [8:0] q);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      7'h04: r = s.vis.press[7:0];
      7'h05: r = s.vis.press[15:8];
      7'h06: r = s.vis.press[23:16];
      7'h07: r = s.vis.temp[7:0];
      7'h08: r = s.vis.temp[15:8];
      7'h09: r = s.vis.temp[23:16];
      sirq_pkg::ADDR_INT_STATUS: begin
        r[sirq_pkg::STAT_FWM_BIT] = s.fwm;
        r[sirq_pkg::STAT_FFULL_BIT] = s.ffull;
        r[sirq_pkg::STAT_DRDY_BIT] = s.drdy;
      end
      sirq_pkg::ADDR_QLEN_0: r = q[7:0];
      sirq_pkg::ADDR_QLEN_1: r = {7'h00, q[8]};
      sirq_pkg::ADDR_WTM_LOW: r = s.wtm_lo;
      sirq_pkg::ADDR_WTM_HIGH: r = s.wtm_hi;
      sirq_pkg::ADDR_INT_CTRL: r = s.int_ctrl;
      sirq_pkg::ADDR_PWR_CTRL: r = s.pwr;
      sirq_pkg::ADDR_OSR: r = s.osr;
      sirq_pkg::ADDR_ODR: r = s.odr;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic is_result(input logic [6:0] a);
    return (a >= sirq_pkg::ADDR_PRESS_0) && (a <= sirq_pkg::ADDR_TEMP_2);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    cs_sel = ~lvl[0];
    cs_rise = rise[0];
    cs_fall = fall[0];
    sck_rise = rise[1];
    sck_fall = fall[1];
    latch = st.int_ctrl[sirq_pkg::INT_LATCH_BIT];
    full_cond = QUEUE_BYTES >= sirq_pkg::FULL_LEVEL;
    wtm_cond = (st.wtm_eff != 9'h000)
               && (QUEUE_BYTES >= st.wtm_eff);
    byte_in = {st.rx[6:0], lvl[2]};
    rd_addr = st.addr;
    do_load = 1'b0;
    clr = 3'b000;
    next_st = st;
    next_st.forced_start = 1'b0;

    // ----------------------------------------
    // Serial slave: mode 0, command byte then auto-incremented data
    // ----------------------------------------
    if (cs_fall) begin
      next_st.bit_cnt = 3'h0;
      next_st.first = 1'b1;
      next_st.is_read = 1'b0;
      next_st.clr_mask = 3'b000;
      next_st.wtm_written = 1'b0;
    end else if (cs_sel && sck_rise) begin
      next_st.rx = byte_in;
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == 3'h7) begin
        if (st.first) begin
          next_st.first = 1'b0;
          next_st.is_read = byte_in[7];
          next_st.addr = byte_in[6:0];
          rd_addr = byte_in[6:0];
          do_load = byte_in[7];
        end else if (st.is_read) begin
          clr = st.clr_mask;
          next_st.addr = st.addr + 7'h01;
          rd_addr = st.addr + 7'h01;
          do_load = 1'b1;
        end else begin
          next_st.addr = st.addr + 7'h01;
          case (st.addr)
            sirq_pkg::ADDR_WTM_LOW: begin
              next_st.wtm_lo = byte_in;
              next_st.wtm_written = 1'b1;
            end
            sirq_pkg::ADDR_WTM_HIGH: begin
              next_st.wtm_hi = byte_in & sirq_pkg::MASK_WTM_HIGH;
              next_st.wtm_written = 1'b1;
            end
            sirq_pkg::ADDR_INT_CTRL: begin
              next_st.int_ctrl = byte_in & sirq_pkg::MASK_INT_CTRL;
            end
            sirq_pkg::ADDR_PWR_CTRL: begin
              next_st.pwr = byte_in & sirq_pkg::MASK_PWR_CTRL;
              next_st.forced_start =
                  (byte_in[sirq_pkg::PWR_MODE_LSB +: 2] ==
                   sirq_pkg::MODE_FORCED_A) ||
                  (byte_in[sirq_pkg::PWR_MODE_LSB +: 2] ==
                   sirq_pkg::MODE_FORCED_B);
            end
            sirq_pkg::ADDR_OSR: next_st.osr = byte_in & sirq_pkg::MASK_OSR;
            sirq_pkg::ADDR_ODR: next_st.odr = byte_in & sirq_pkg::MASK_ODR;
            default: next_st.rx = byte_in;
          endcase
        end
      end
    end else if (cs_sel && sck_fall && st.bit_cnt != 3'h0) begin
      // First falling edge after a load is skipped so bit 7 holds
      next_st.tx = {st.tx[6:0], 1'b0};
    end

    // ----------------------------------------
    // Byte loaded for output: note what it will clear and if it is a result
    // ----------------------------------------
    if (do_load) begin
      next_st.tx = read_reg(rd_addr, st, QUEUE_BYTES);
      next_st.clr_mask = 3'b000;
      if (rd_addr == sirq_pkg::ADDR_INT_STATUS) begin
        next_st.clr_mask = {st.drdy, st.ffull, st.fwm};
      end
      if (is_result(rd_addr)) begin
        next_st.result_reading = 1'b1;
      end
    end

    // ----------------------------------------
    // End of transaction
    // ----------------------------------------
    if (cs_rise) begin
      clr = st.clr_mask;
      next_st.clr_mask = 3'b000;
      // Drop read state now, so the next select fall cannot enable the data out
      next_st.is_read = 1'b0;
      next_st.first = 1'b1;
      next_st.result_reading = 1'b0;
      if (st.wtm_written) begin
        next_st.wtm_eff = {st.wtm_hi[0], st.wtm_lo};
      end
      if (st.shadow_pending) begin
        next_st.vis = st.shadow;
        next_st.shadow_pending = 1'b0;
      end
    end

    // ----------------------------------------
    // Status bits: clear first, then any event of this cycle wins
    // ----------------------------------------
    next_st.fwm = (st.fwm & ~clr[0]) | wtm_cond;
    next_st.ffull = (st.ffull & ~(clr[1] & ~full_cond)) | full_cond;
    next_st.drdy = (st.drdy & ~clr[2]) | conv_done;

    // ----------------------------------------
    // Data-ready pin contribution and its self-clear timer
    // ----------------------------------------
    if (clr[2] || !st.int_ctrl[sirq_pkg::DRDY_EN_BIT]) begin
      next_st.drdy_pin = 1'b0;
    end
    if (st.drdy_run) begin
      if (st.drdy_timer <= 20'h1) begin
        next_st.drdy_run = 1'b0;
        if (!latch) begin
          next_st.drdy_pin = 1'b0;
        end
      end else begin
        next_st.drdy_timer = st.drdy_timer - 20'h1;
      end
    end
    if (conv_done) begin
      next_st.drdy_pin = st.int_ctrl[sirq_pkg::DRDY_EN_BIT];
      // Timer only armed by an event seen in non-latched mode
      next_st.drdy_run = ~latch;
      next_st.drdy_timer = 20'(DRDY_HOLD_CYCLES);
    end

    // ----------------------------------------
    // Results: shadow while a result burst is open
    // ----------------------------------------
    next_st.done_out = conv_done;
    if (conv_done) begin
      if (st.result_reading && !cs_rise) begin
        next_st.shadow = MEASUREMENT_SAMPLE;
        next_st.shadow_pending = 1'b1;
      end else begin
        next_st.vis = MEASUREMENT_SAMPLE;
      end
      if (st.pwr[sirq_pkg::PWR_MODE_LSB +: 2] != sirq_pkg::MODE_NORMAL) begin
        next_st.pwr[sirq_pkg::PWR_MODE_LSB +: 2] = sirq_pkg::MODE_SLEEP;
      end
    end

    // ----------------------------------------
    // Pin: source selection, OR, polarity and drive
    // ----------------------------------------
    c_fwm = st.int_ctrl[sirq_pkg::FWTM_EN_BIT] &
            (latch ? st.fwm : wtm_cond);
    c_full = st.int_ctrl[sirq_pkg::FFULL_EN_BIT] &
             (latch ? st.ffull : full_cond);
    active = c_fwm | c_full | st.drdy_pin;
    if (st.int_ctrl[sirq_pkg::IRQ_OPEN_DRAIN_SELECT_BIT]) begin
      // Open drain only pulls low; the high level comes from outside
      next_st.irq_out = 1'b0;
      next_st.irq_oe = (active != st.int_ctrl[sirq_pkg::INT_LEVEL_BIT]);
    end else begin
      next_st.irq_out = (active == st.int_ctrl[sirq_pkg::INT_LEVEL_BIT]);
      next_st.irq_oe = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '0;
      st.first <= 1'b1;
      st.int_ctrl <= sirq_pkg::RST_INT_CTRL;
      st.wtm_lo <= sirq_pkg::RST_WTM_LOW;
      st.wtm_hi <= sirq_pkg::RST_WTM_HIGH;
      st.wtm_eff <= {sirq_pkg::RST_WTM_HIGH[0], sirq_pkg::RST_WTM_LOW};
      st.pwr <= sirq_pkg::RST_PWR_CTRL;
      st.osr <= sirq_pkg::RST_OSR;
      st.odr <= sirq_pkg::RST_ODR;
      st.irq_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign SERIAL_DATA_OUT = st.tx[7];
  assign SERIAL_DATA_OE = ~lvl[0] & st.is_read & ~st.first;
  assign MEASURE_DONE = st.done_out;
  assign IRQ_OUT = st.irq_out;
  assign IRQ_OE = st.irq_oe;
endmodule

// ---- bench/sirq_assertions.sv ----
/*
  Port checker for sirq_top, bound into every instance.
  Assumes one clock domain and the synchronous reset.
*/
`timescale 1ns/1ps
module sirq_chk #(
  parameter int US_CYCLES = 50
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_DATA_OE,
  input wire logic MEASURE_DONE,
  input wire logic IRQ_OUT,
  input wire logic IRQ_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  localparam int MIN_GAP = 234 * US_CYCLES;
  // Saturates, so the first result after reset is never judged
  logic [15:0] gap;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gap <= 16'hffff;
    end else if (MEASURE_DONE) begin
      gap <= 16'h0000;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  pin_reset_a: assert property ($fell(RESET) |-> IRQ_OE && !IRQ_OUT)
    else $error("irq pin not idle after reset");
  done_reset_a: assert property ($fell(RESET) |-> !MEASURE_DONE)
    else $error("done pulse after reset");
  oe_reset_a: assert property ($fell(RESET) |-> !SERIAL_DATA_OE)
    else $error("data output driven after reset");
  done_pulse_a: assert property (MEASURE_DONE |=> !MEASURE_DONE)
    else $error("done longer than one cycle");
  done_gap_a: assert property (MEASURE_DONE |-> gap >= MIN_GAP)
    else $error("conversion shorter than base time");
  idle_oe_a: assert property (CHIP_SELECT_N [*8] |-> !SERIAL_DATA_OE)
    else $error("data output driven while idle");
  oe_rise_a: assert property ($rose(SERIAL_DATA_OE) |->
    !CHIP_SELECT_N && !$past(CHIP_SELECT_N, 8))
    else $error("data output without command byte");
  oe_fall_a: assert property ($fell(SERIAL_DATA_OE) |->
    $past(CHIP_SELECT_N, 2))
    else $error("data output dropped inside burst");
endmodule
bind sirq_top sirq_chk #(.US_CYCLES(US_CYCLES)) chk (
  .CLOCK(CLOCK), .RESET(RESET), .CHIP_SELECT_N(CHIP_SELECT_N),
  .SERIAL_DATA_OE(SERIAL_DATA_OE), .MEASURE_DONE(MEASURE_DONE),
  .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE));

// ---- bench/sirq_host.sv ----
/*
  Host model on the serial register link, mode 0, MSB first.
  Assumes clk is the system clock; SCK runs at 160 ns.
*/
`timescale 1ns/1ps
module sirq_host (
  input wire logic clk,
  input wire logic sdo,
  output logic sel_n,
  output logic sck,
  output logic sdi
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Released data line toggles, so no stale bit passes for valid
  always @(negedge clk) begin
    if (sel_n) begin
      sdi <= ~sdi;
    end
  end
  task automatic go(input logic s);
    repeat (8) @(negedge clk);
    sel_n = s;
    repeat (8) @(negedge clk);
  endtask
  // Sample late in the high phase: the device shifts several cycles
  // after each fall, so the bit is settled by then
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      q[i] = sdo;
      sck = 1'b0;
    end
  endtask
endmodule

// ---- bench/tb.sv ----
/*
  Self-checking bench for sirq_top with short timing parameters.
  Assumes sirq_host for the link and the bound port checker.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] ST = sirq_pkg::ADDR_INT_STATUS;
  localparam logic [6:0] IC = sirq_pkg::ADDR_INT_CTRL;
  localparam logic [6:0] PW = sirq_pkg::ADDR_PWR_CTRL;
  localparam logic [6:0] RS = sirq_pkg::ADDR_PRESS_0;
  localparam logic [6:0] WL = sirq_pkg::ADDR_WTM_LOW;
  localparam int CONV = (234 + 392 + 2020) * 2;
  localparam logic [47:0] A = {24'h123456, 24'h0a0b0c};
  localparam logic [47:0] B = {24'hfedcba, 24'h987654};
  logic clock, reset, sdo, oe, done, irq, irq_oe, sel_n, sck, sdi;
  logic [8:0] queue;
  sirq_pkg::sirq_result_type sample;
  logic [7:0] wb [6];
  logic [7:0] rb [6];
  logic [7:0] q;
  int checked, error_cnt, n;
  sirq_top #(.US_CYCLES(2), .DRDY_HOLD_CYCLES(20)) DUT (
    .CLOCK(clock), .RESET(reset), .CHIP_SELECT_N(sel_n),
    .SERIAL_CLOCK(sck), .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OE(oe), .QUEUE_BYTES(queue), .MEASUREMENT_SAMPLE(sample),
    .MEASURE_DONE(done), .IRQ_OUT(irq), .IRQ_OE(irq_oe));
  sirq_host h (.clk(clock), .sdo(oe ? sdo : ~sdo), .sel_n(sel_n),
    .sck(sck), .sdi(sdi));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string s, input logic [47:0] e,
    input logic [47:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(input logic [7:0] cmd, input int k);
    h.go(1'b0);
    h.xb(cmd, q);
    for (int i = 0; i < k; i++) h.xb(wb[i], rb[i]);
    h.go(1'b1);
  endtask
  task automatic rd(input logic [6:0] a);
    acc({1'b1, a}, 1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wb[0] = d;
    acc({1'b0, a}, 1);
  endtask
  task automatic wdone(output int c);
    c = 0;
    while (done !== 1'b1 && c < 30000) begin
      @(negedge clock);
      c++;
    end
  endtask
  function automatic logic [47:0] res();
    return {rb[2], rb[1], rb[0], rb[5], rb[4], rb[3]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    queue = 9'h000;
    sample = A;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    chk("irq_oe", 1, irq_oe);
    chk("irq", 0, irq);
    rd(IC);
    chk("int_ctrl", sirq_pkg::RST_INT_CTRL, rb[0]);
    $display("reset test done");
    wb[0] = 8'h03;
    wb[1] = 8'h00;
    acc({1'b0, WL}, 2);
    queue = 9'd2;
    rd(ST);
    chk("fwm", 0, rb[0][0]);
    queue = 9'd3;
    rd(ST);
    chk("fwm", 1, rb[0][0]);
    wb[0] = 8'h00;
    acc({1'b0, WL}, 2);
    rd(ST);
    rd(ST);
    chk("fwm_zero", 0, rb[0][0]);
    $display("watermark test done");
    queue = 9'd504;
    rd(ST);
    chk("ffull", 1, rb[0][1]);
    chk("irq_off", 0, irq);
    wr(IC, 8'h16);
    chk("irq_full", 1, irq);
    queue = 9'd503;
    wr(IC, 8'h12);
    chk("irq_live", 0, irq);
    rd(ST);
    chk("ffull", 1, rb[0][1]);
    rd(ST);
    chk("ffull", 0, rb[0][1]);
    $display("full test done");
    queue = 9'd0;
    wr(IC, 8'h46);
    wr(sirq_pkg::ADDR_OSR, 8'h00);
    wr(PW, 8'h11);
    wdone(n);
    chk("conv", 1, n >= CONV - 60 && n <= CONV + 8);
    @(negedge clock);
    chk("irq_drdy", 1, irq);
    acc({1'b1, RS}, 6);
    chk("result", A, res());
    rd(ST);
    chk("drdy", 1, rb[0][3]);
    chk("irq_clr", 0, irq);
    rd(ST);
    chk("drdy", 0, rb[0][3]);
    $display("data ready test done");
    wr(IC, 8'h42);
    sample = B;
    wr(PW, 8'h11);
    h.go(1'b0);
    h.xb({1'b1, RS}, q);
    h.xb(8'h00, rb[0]);
    wdone(n);
    @(negedge clock);
    chk("irq_pulse", 1, irq);
    repeat (25) @(negedge clock);
    chk("irq_self", 0, irq);
    for (int i = 1; i < 6; i++) h.xb(8'h00, rb[i]);
    h.go(1'b1);
    chk("shadow", A, res());
    acc({1'b1, RS}, 6);
    chk("copied", B, res());
    wr(IC, 8'h02);
    wr(IC, 8'h46);
    chk("irq_late", 0, irq);
    $display("shadow test done");
    wr(PW, 8'h11);
    wdone(n);
    wr(IC, 8'h42);
    repeat (25) @(negedge clock);
    chk("irq_hold", 1, irq);
    $display("mode switch test done");
    end_sim();
  end
endmodule
